/* File: shared/sdcb_regs.vh */
/*
 * Constants of the command and clock-enable control: bank states,
 * device modes, command pin codes and address bit positions.
 * Assumes inclusion by bare name from design files only.
 */
`ifndef SDCB_REGS_VH
`define SDCB_REGS_VH

// Per-bank state codes
`define SDCB_BS_IDLE 3'h0
`define SDCB_BS_ACTIVE 3'h1
`define SDCB_BS_READ 3'h2
`define SDCB_BS_WRITE 3'h3
`define SDCB_BS_READ_AP 3'h4
`define SDCB_BS_WRITE_AP 3'h5

// Device-wide mode codes
`define SDCB_MD_NORMAL 3'h0
`define SDCB_MD_POWER_DOWN 3'h1
`define SDCB_MD_SUSPEND 3'h2
`define SDCB_MD_SELF_REFRESH 3'h3
`define SDCB_MD_MODE_WAIT 3'h4

// Command codes {ras_n, cas_n, we_n} with chip select low
`define SDCB_CMD_NOP 3'h7
`define SDCB_CMD_BURST_STOP 3'h6
`define SDCB_CMD_READ 3'h5
`define SDCB_CMD_WRITE 3'h4
`define SDCB_CMD_ACTIVATE 3'h3
`define SDCB_CMD_PRECHARGE 3'h2
`define SDCB_CMD_REFRESH 3'h1
`define SDCB_CMD_MODE_LOAD 3'h0

// Address fields and the mode-wait cycle count
`define SDCB_ADDR_W 10
`define SDCB_BANK_SELECT_BIT 9
`define SDCB_PRECHARGE_SCOPE_BIT 8
`define SDCB_COL_MSB 7
`define SDCB_ROW_MSB 8
`define SDCB_BL_MSB 2
`define SDCB_BL_FULL_PAGE 3'h7
`define SDCB_MODE_RESET 10'h000
`define SDCB_ROW_RESET 9'h000
`define SDCB_COL_RESET 8'h00
`define SDCB_MODE_WAIT_CYCLES 2'h2

`endif

/* File: hdl/sdcb_bank_state.v */
/*
 * One bank's next-state logic: activate, read, write, burst stop and
 * precharge as seen by a single bank, holding the bank state and row.
 * Assumes the caller decodes the command and gates it with the
 * device clock enable.
 */
`timescale 1ns/1ps
`include "sdcb_regs.vh"

module sdcb_bank_state #(
    parameter BANK_ID = 1'b0
) (
    input wire clk_sys,
    input wire rst_n,
    input wire cmd_valid,
    input wire [2:0] cmd_code,
    input wire bank_bit,
    input wire scope_bit,
    input wire stop_allowed,
    input wire [`SDCB_ROW_MSB:0] row_addr,
    output reg [2:0] state_reg,
    output reg [`SDCB_ROW_MSB:0] row_reg
);

    reg [2:0] state_next;
    wire hit;

    assign hit = (bank_bit == BANK_ID);

    ////////////////////////////////////////////////////////////////////
    // Next state of this bank for the command in this cycle
    always @* begin
        state_next = state_reg;
        if (cmd_valid) begin
            case (cmd_code)
                `SDCB_CMD_ACTIVATE: begin
                    if (hit && state_reg == `SDCB_BS_IDLE) begin
                        state_next = `SDCB_BS_ACTIVE;
                    end
                end
                `SDCB_CMD_READ: begin
                    if (hit && state_reg != `SDCB_BS_IDLE) begin
                        state_next = scope_bit ? `SDCB_BS_READ_AP : `SDCB_BS_READ;
                    end else if (!hit && state_reg != `SDCB_BS_IDLE) begin
                        state_next = `SDCB_BS_ACTIVE; // Other bank's burst is cut short
                    end
                end
                `SDCB_CMD_WRITE: begin
                    if (hit && state_reg != `SDCB_BS_IDLE) begin
                        state_next = scope_bit ? `SDCB_BS_WRITE_AP : `SDCB_BS_WRITE;
                    end else if (!hit && state_reg != `SDCB_BS_IDLE) begin
                        state_next = `SDCB_BS_ACTIVE;
                    end
                end
                `SDCB_CMD_BURST_STOP: begin
                    // Auto-precharge bursts cannot be stopped back to active
                    if (stop_allowed && (state_reg == `SDCB_BS_READ ||
                            state_reg == `SDCB_BS_WRITE)) begin
                        state_next = `SDCB_BS_ACTIVE;
                    end
                end
                `SDCB_CMD_PRECHARGE: begin
                    if (scope_bit || hit) begin
                        state_next = `SDCB_BS_IDLE;
                    end
                end
                default: begin
                    state_next = state_reg;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State and open row registers
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= `SDCB_BS_IDLE;
            row_reg <= `SDCB_ROW_RESET;
        end else begin
            state_reg <= state_next;
            if (cmd_valid && cmd_code == `SDCB_CMD_ACTIVATE && hit &&
                    state_reg == `SDCB_BS_IDLE) begin
                row_reg <= row_addr;
            end
        end
    end

endmodule

/* File: hdl/sdcb_cke_control.v */
/*
 * Clock-enable and command control of a two-bank synchronous DRAM:
 * power-down, clock suspend, self-refresh, mode load and the per-bank
 * command decode. Assumes pins are synchronous to clk_sys and that
 * the controller keeps its own timing and ordering duties.
 */
`timescale 1ns/1ps
`include "sdcb_regs.vh"

module sdcb_cke_control (
    input wire clk_sys,
    input wire rst_n,
    input wire cke,
    input wire cs_n,
    input wire ras_n,
    input wire cas_n,
    input wire we_n,
    input wire [`SDCB_ADDR_W-1:0] addr,
    output reg [2:0] mode_reg,
    output reg clock_running_reg,
    output reg [2:0] bank0_state_reg,
    output reg [2:0] bank1_state_reg,
    output reg [`SDCB_ADDR_W-1:0] opcode_reg,
    output reg [`SDCB_COL_MSB:0] column_reg,
    output reg access_bank_reg,
    output reg illegal_cmd_reg
);

    reg cke_prev_reg;
    reg [2:0] mode_next;
    reg [1:0] wait_cnt_reg;
    reg illegal_next;
    wire [2:0] cmd;
    wire cmd_sel;
    wire both_idle;
    wire cmd_valid;
    wire stop_allowed;
    wire [2:0] b0_state;
    wire [2:0] b1_state;
    wire [`SDCB_ROW_MSB:0] b0_row;
    wire [`SDCB_ROW_MSB:0] b1_row;

    // Decodes the three strobes into a command code; used once
    function [2:0] cmd_of;
        input r;
        input c;
        input w;
        begin
            cmd_of = {r, c, w};
        end
    endfunction

    assign cmd = cmd_of(ras_n, cas_n, we_n);
    assign cmd_sel = !cs_n;
    assign both_idle = (b0_state == `SDCB_BS_IDLE) && (b1_state == `SDCB_BS_IDLE);
    assign stop_allowed = (opcode_reg[`SDCB_BL_MSB:0] == `SDCB_BL_FULL_PAGE);
    // Commands act only in normal or mode-wait mode with clock enable high on both edges.
    // The mode-wait window is the controller's to keep, so commands still decode.
    assign cmd_valid = cmd_sel && cke_prev_reg && cke &&
        (mode_reg == `SDCB_MD_NORMAL || mode_reg == `SDCB_MD_MODE_WAIT);

    ////////////////////////////////////////////////////////////////////
    // Bank state machines, one per bank
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_bank
            wire [2:0] st;
            wire [`SDCB_ROW_MSB:0] rw;
            sdcb_bank_state #(
                .BANK_ID(gi)
            ) u_bank (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .cmd_valid(cmd_valid),
                .cmd_code(cmd),
                .bank_bit(addr[`SDCB_BANK_SELECT_BIT]),
                .scope_bit(addr[`SDCB_PRECHARGE_SCOPE_BIT]),
                .stop_allowed(stop_allowed),
                .row_addr(addr[`SDCB_ROW_MSB:0]),
                .state_reg(st),
                .row_reg(rw)
            );
        end
    endgenerate

    assign b0_state = g_bank[0].st;
    assign b1_state = g_bank[1].st;
    assign b0_row = g_bank[0].rw;
    assign b1_row = g_bank[1].rw;

    ////////////////////////////////////////////////////////////////////
    // Device mode: uses clock enable on the previous and current edge.
    // The asynchronous restart of the clock is modelled by acting on
    // the first edge at which clock enable is seen high again.
    always @* begin
        mode_next = mode_reg;
        illegal_next = 1'b0;
        case (mode_reg)
            `SDCB_MD_POWER_DOWN: begin
                if (!cke_prev_reg && cke) begin
                    mode_next = `SDCB_MD_NORMAL;
                end
            end
            `SDCB_MD_SUSPEND: begin
                if (!cke_prev_reg && cke) begin
                    mode_next = `SDCB_MD_NORMAL;
                end
            end
            `SDCB_MD_SELF_REFRESH: begin
                // Recovery needs select high or row and column strobes both high
                if (!cke_prev_reg && cke) begin
                    if (!cmd_sel || (ras_n && cas_n)) begin
                        mode_next = `SDCB_MD_NORMAL;
                    end else begin
                        illegal_next = 1'b1;
                    end
                end
            end
            `SDCB_MD_NORMAL, `SDCB_MD_MODE_WAIT: begin
                if (mode_reg == `SDCB_MD_MODE_WAIT && wait_cnt_reg == 2'h1) begin
                    mode_next = `SDCB_MD_NORMAL;
                end
                if (cke_prev_reg && !cke) begin
                    if (!both_idle) begin
                        mode_next = `SDCB_MD_SUSPEND;
                    end else if (cmd_sel && cmd == `SDCB_CMD_REFRESH) begin
                        mode_next = `SDCB_MD_SELF_REFRESH;
                    end else begin
                        mode_next = `SDCB_MD_POWER_DOWN;
                    end
                end else if (!cke_prev_reg) begin
                    mode_next = `SDCB_MD_POWER_DOWN;
                end else if (cmd_valid && cmd == `SDCB_CMD_MODE_LOAD) begin
                    if (both_idle) begin
                        mode_next = `SDCB_MD_MODE_WAIT;
                    end else begin
                        illegal_next = 1'b1;
                    end
                end else if (cmd_valid && mode_reg == `SDCB_MD_MODE_WAIT &&
                        cmd != `SDCB_CMD_NOP && cmd != `SDCB_CMD_BURST_STOP) begin
                    illegal_next = 1'b1;
                end
            end
            default: begin
                mode_next = `SDCB_MD_NORMAL;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Registers; every output comes straight from one of these
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= `SDCB_MD_NORMAL;
            cke_prev_reg <= 1'b1;
            clock_running_reg <= 1'b1;
            wait_cnt_reg <= 2'h0;
            bank0_state_reg <= `SDCB_BS_IDLE;
            bank1_state_reg <= `SDCB_BS_IDLE;
            opcode_reg <= `SDCB_MODE_RESET;
            column_reg <= `SDCB_COL_RESET;
            access_bank_reg <= 1'b0;
            illegal_cmd_reg <= 1'b0;
        end else begin
            cke_prev_reg <= cke;
            mode_reg <= mode_next;
            // Internal clock stops in suspend and power states
            clock_running_reg <= (mode_next == `SDCB_MD_NORMAL) ||
                (mode_next == `SDCB_MD_MODE_WAIT);
            bank0_state_reg <= b0_state;
            bank1_state_reg <= b1_state;
            illegal_cmd_reg <= illegal_next;
            if (cmd_valid && cmd == `SDCB_CMD_MODE_LOAD && both_idle) begin
                opcode_reg <= addr;
                wait_cnt_reg <= `SDCB_MODE_WAIT_CYCLES;
            end else if (wait_cnt_reg != 2'h0) begin
                wait_cnt_reg <= wait_cnt_reg - 2'h1;
            end
            if (cmd_valid && (cmd == `SDCB_CMD_READ || cmd == `SDCB_CMD_WRITE)) begin
                column_reg <= addr[`SDCB_COL_MSB:0];
                access_bank_reg <= addr[`SDCB_BANK_SELECT_BIT];
            end
        end
    end

endmodule

/* File: tb/sdcb_chk_assertions.sv */
/* Checker of the command and clock-enable control.
   Assumes it is bound to sdcb_cke_control and sees only its ports. */
`timescale 1ns/1ps
module sdcb_chk (
    input wire clk_sys, input wire rst_n, input wire cke, input wire cs_n,
    input wire ras_n, input wire cas_n, input wire we_n, input wire [9:0] addr,
    input wire [2:0] mode_reg, input wire clock_running_reg,
    input wire [2:0] bank0_state_reg, input wire [2:0] bank1_state_reg,
    input wire [9:0] opcode_reg, input wire [7:0] column_reg,
    input wire access_bank_reg, input wire illegal_cmd_reg
);
    reg ck1_reg;
    wire go;
    wire [2:0] op;
    wire idle;
    // Previous clock enable; taken as high in reset like the device
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ck1_reg <= 1'b0 | 1'b1;
        end else begin
            ck1_reg <= cke;
        end
    end
    // Command taken in normal mode; stays quiet through resume edges
    assign op = {ras_n, cas_n, we_n};
    assign go = !cs_n && cke && ck1_reg && mode_reg == 3'h0;
    assign idle = bank0_state_reg == 3'h0 && bank1_state_reg == 3'h0;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////
    a_pd_exit: assert property (mode_reg == 3'h1 && !ck1_reg && cke |=>
        mode_reg == 3'h0 && clock_running_reg) else $error("power-down not left");
    a_susp_in: assert property (mode_reg == 3'h0 && ck1_reg && !cke && !idle &&
        !$past(go) |=> mode_reg == 3'h2) else $error("suspend not entered");
    a_susp_out: assert property ($rose(cke) && mode_reg == 3'h2 |=>
        mode_reg == 3'h0) else $error("suspend not left");
    a_act_bank: assert property (go && op == 3'h3 && addr[9] && !$past(go) &&
        bank1_state_reg == 3'h0 |-> ##2 bank1_state_reg == 3'h1) else $error("no activate");
    a_pre_all: assert property (go && op == 3'h2 && addr[8] |-> ##2 idle)
        else $error("banks not closed");
    a_read_ap: assert property (go && op == 3'h5 && addr[8] && !addr[9] && !$past(go) &&
        bank0_state_reg == 3'h1 |-> ##2 bank0_state_reg == 3'h4) else $error("no auto-precharge");
    a_mode_load: assert property (go && op == 3'h0 && idle && !$past(go) |->
        ##2 opcode_reg == $past(addr, 2)) else $error("opcode not loaded");
    a_stop_off: assert property (go && op == 3'h6 && opcode_reg[2:0] != 3'h7 |->
        ##2 bank0_state_reg == $past(bank0_state_reg)) else $error("burst stop taken");
endmodule
bind sdcb_cke_control sdcb_chk chk (.clk_sys(clk_sys), .rst_n(rst_n), .cke(cke),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr),
    .mode_reg(mode_reg), .clock_running_reg(clock_running_reg),
    .bank0_state_reg(bank0_state_reg), .bank1_state_reg(bank1_state_reg),
    .opcode_reg(opcode_reg), .column_reg(column_reg),
    .access_bank_reg(access_bank_reg), .illegal_cmd_reg(illegal_cmd_reg));

/* File: tb/sdcb_ctrl_model.sv */
/* Controller model: drives command, address and clock-enable pins.
   Assumes a free-running clk_sys; commands come by task call. */
`timescale 1ns/1ps
module sdcb_ctrl_model (
    input wire clk_sys,
    output reg cke,
    output reg cs_n,
    output reg ras_n,
    output reg cas_n,
    output reg we_n,
    output reg [9:0] addr
);
    // Deselected with clock enable high from time zero
    initial begin
        cke = 1'b1;
        cs_n = 1'b1;
        {ras_n, cas_n, we_n} = 3'h7;
        addr = 10'h000;
    end
    // One cycle of command, then deselect with scrambled pins
    task cmd(input [2:0] c, input [9:0] a, input k);
        begin
            @(posedge clk_sys);
            cs_n <= 1'b0;
            {ras_n, cas_n, we_n} <= c;
            addr <= a;
            cke <= k;
            @(posedge clk_sys);
            cs_n <= 1'b1;
            {ras_n, cas_n, we_n} <= ~c;
            addr <= ~a;
            // Mode load needs two quiet cycles before anything else
            if (c == 3'h0) repeat (2) @(posedge clk_sys);
        end
    endtask
endmodule

/* File: tb/sdcb_cke_and_bank_command_control_bench.sv */
/* Bench of the command and clock-enable control.
   Assumes the controller model and the bound checker. */
`timescale 1ns/1ps
module sdcb_cke_and_bank_command_control_bench;
    reg clk_sys = 1'b0;
    reg rst_n = 1'b0;
    wire k, cs, ras, cas, we, run, abk, ill;
    wire [9:0] a, opc;
    wire [2:0] md, b0, b1;
    wire [7:0] col;
    integer err_total = 0;
    integer checked = 0;
    integer ill_seen = 0;
    // Clock at 200 MHz
    always #2.5 clk_sys = ~clk_sys;
    sdcb_ctrl_model pm (.clk_sys(clk_sys), .cke(k), .cs_n(cs), .ras_n(ras),
        .cas_n(cas), .we_n(we), .addr(a));
    sdcb_cke_control dut (.clk_sys(clk_sys), .rst_n(rst_n), .cke(k), .cs_n(cs),
        .ras_n(ras), .cas_n(cas), .we_n(we), .addr(a), .mode_reg(md),
        .clock_running_reg(run), .bank0_state_reg(b0), .bank1_state_reg(b1),
        .opcode_reg(opc), .column_reg(col), .access_bank_reg(abk), .illegal_cmd_reg(ill));
    // Illegal flag stands one cycle only, so count its pulses as they pass
    always @(posedge clk_sys) begin
        if (ill === 1'b1) begin
            ill_seen <= ill_seen + 1;
        end
    end
    ////////////////////////////////////////////////////////////
    // Four-state compare, so an unknown never matches
    task chk(input [9:0] got, input [9:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    // State shows two edges after the command is driven
    task go(input [2:0] c, input [9:0] ad, input ke);
        begin
            pm.cmd(c, ad, ke);
            @(posedge clk_sys);
            #1;
        end
    endtask
    ////////////////////////////////////////////////////////////
    task t_bank;
        begin
            go(3'h3, 10'h2ab, 1'b1);
            chk(b1, 3'h1);
            // Mode load with a bank open is refused and flagged
            go(3'h0, 10'h0ff, 1'b1);
            chk(ill_seen, 10'h001);
            chk(opc, 10'h000);
            go(3'h3, 10'h001, 1'b1);
            go(3'h2, 10'h200, 1'b1);
            chk({b1, b0}, 6'h01);
            go(3'h3, 10'h206, 1'b1);
            go(3'h5, 10'h15a, 1'b1);
            chk(b0, 3'h4);
            chk({abk, col}, 9'h05a);
            go(3'h4, 10'h2c3, 1'b1);
            chk({abk, b1}, 4'hb);
            go(3'h4, 10'h3c3, 1'b1);
            chk(b1, 3'h5);
            go(3'h2, 10'h100, 1'b1);
            chk({b1, b0}, 6'h00);
            $display("bank test done");
        end
    endtask
    // Burst stop under full page, then refused under a burst of eight
    task t_mode;
        begin
            go(3'h0, 10'h037, 1'b1);
            chk(opc, 10'h037);
            go(3'h3, 10'h001, 1'b1);
            go(3'h5, 10'h001, 1'b1);
            go(3'h6, 10'h000, 1'b1);
            chk(b0, 3'h1);
            go(3'h2, 10'h100, 1'b1);
            go(3'h0, 10'h033, 1'b1);
            go(3'h3, 10'h001, 1'b1);
            go(3'h5, 10'h001, 1'b1);
            go(3'h6, 10'h000, 1'b1);
            chk(b0, 3'h2);
            go(3'h2, 10'h100, 1'b1);
            $display("mode test done");
        end
    endtask
    // Banks idle before power-down and self-refresh entry
    task t_cke;
        begin
            go(3'h7, 10'h000, 1'b0);
            chk({md, run}, 4'h2);
            go(3'h7, 10'h000, 1'b1);
            chk({md, run}, 4'h1);
            go(3'h3, 10'h001, 1'b1);
            go(3'h7, 10'h000, 1'b0);
            chk(md, 3'h2);
            go(3'h3, 10'h200, 1'b0);
            go(3'h7, 10'h000, 1'b1);
            chk({md, b1}, 6'h00);
            go(3'h2, 10'h100, 1'b1);
            go(3'h1, 10'h000, 1'b0);
            chk(md, 3'h3);
            // Recovery with row strobe low is illegal and stays put
            go(3'h3, 10'h000, 1'b1);
            chk(ill_seen, 10'h002);
            chk(md, 3'h3);
            go(3'h7, 10'h000, 1'b0);
            go(3'h7, 10'h000, 1'b1);
            chk({md, run}, 4'h1);
            $display("clock enable test done");
        end
    endtask
    task end_sim;
        begin
            $display("checked %0d mismatches %0d", checked, err_total);
            if (err_total == 0 && checked > 0) begin
                $display("Result: passed");
            end else begin
                $display("Result: failed");
            end
            $finish;
        end
    endtask
    // Reset for two cycles, then the tests in order
    initial begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_bank;
        t_mode;
        t_cke;
        end_sim;
    end
    // Whole run is about a hundred cycles; this is ample
    initial begin
        #20000;
        err_total = err_total + 1;
        end_sim;
    end
endmodule
